// ### core/epm_defs.vh
// Purpose: constants for the engine protection monitor
// Assumes: 100 MHz clk_sys_in, 32-bit classic Wishbone slave, byte address = index * 4
// Notes: thresholds other than the overcurrent limits, and delays, are clamped to their legal ranges where they are used
// Overview of operation
// - with overcurrent warning and shutdown both active, show only the shutdown code
// - overcurrent lasting its 2..60 s delay stops the engine, code 1472
// - 50 Hz overspeed limit 0..1250/1875/3750 rpm for 20/30/60 rpm/Hz, 25 rpm steps
// - 60 Hz overspeed limit 0..1500/2250/4500 rpm for 20/30/60 rpm/Hz, 25 rpm steps
// - speed above overspeed limit shuts down, code 1992; off without electronic governor
// - speed/frequency mismatch limit 0.1..20.0 Hz; beyond it is a conflict
// - conflict lasting its 0.2..10.0 s delay shuts down, code 1469
// - oil pre-warning limit 11..100 psi; pressure at or below it is a warning
// - oil warning lasting 2..15 s announces code 143, engine keeps running
// - oil shutdown limit 9..100 psi; pressure at or below it is a shutdown condition
// - oil shutdown lasting 2..10 s stops the engine, code 415
// - coolant hot warning and shutdown limits each 150..290 degF
// - coolant hot warning lasting 2..10 s announces code 146, engine runs
// - coolant hot shutdown lasting 2..10 s stops the engine, code 151
// - coolant below cold limit for one whole minute announces code 1435
// - coolant cold limit 0..100 degF
// - charger fault when voltage reaches the high or the low limit
// - charger high limit 13.0..20.0 V at 12 V, 25.0..40.0 V at 24 V
// - charger low limit 2.0..13.0 V at 12 V, 2.0..25.0 V at 24 V
// - charger fault lasting 2..300 s announces code 2678
// - battery setting picks 12 V or 24 V charger limit ranges
`ifndef EPM_DEFS_VH
`define EPM_DEFS_VH
`define EPM_R_CTRL 4'h0
`define EPM_R_OC   4'h1
`define EPM_R_SPD  4'h2
`define EPM_R_SF   4'h3
`define EPM_R_OIL  4'h4
`define EPM_R_CT   4'h5
`define EPM_R_UT   4'h6
`define EPM_R_CHG  4'h7
`define EPM_R_DLYA 4'h8
`define EPM_R_DLYB 4'h9
`define EPM_R_DLYC 4'hA
`define EPM_R_DLYD 4'hB
`define EPM_R_STAT 4'hC
`define EPM_R_CODE 4'hD
`define EPM_NCFG   12
`define EPM_B_FRST 0
`define EPM_B_F60  1
`define EPM_B_B24  2
`define EPM_B_GOV  3
`define EPM_RST_CTRL 32'h0000_0008
`define EPM_RST_OC   32'hFFFF_FFFF
`define EPM_RST_SPD  32'h0000_00FF
`define EPM_RST_SF   32'h0000_00C8
`define EPM_RST_OIL  32'h0000_090B
`define EPM_RST_CT   32'h0122_0122
`define EPM_RST_UT   32'h0000_0000
`define EPM_RST_CHG  32'h0014_0190
`define EPM_RST_DLYA 32'h0064_0258
`define EPM_RST_DLYB 32'h0064_0096
`define EPM_RST_DLYC 32'h0064_0064
`define EPM_RST_DLYD 32'h0000_0BB8
`define EPM_TICK_MS  100
`define EPM_CLK_KHZ  100000
`define EPM_UT_S     60
`define EPM_UT_TICKS (`EPM_UT_S * 1000 / `EPM_TICK_MS)
`define EPM_FC_OCS  16'h05C0
`define EPM_FC_OS   16'h07C8
`define EPM_FC_SF   16'h05BD
`define EPM_FC_OILW 16'h008F
`define EPM_FC_OILS 16'h019F
`define EPM_FC_CTW  16'h0092
`define EPM_FC_CTS  16'h0097
`define EPM_FC_UT   16'h059B
`define EPM_FC_CHG  16'h0A76
`define EPM_OS50_20 16'h0032
`define EPM_OS50_30 16'h004B
`define EPM_OS50_60 16'h0096
`define EPM_OS60_20 16'h003C
`define EPM_OS60_30 16'h005A
`define EPM_OS60_60 16'h00B4
`define EPM_SF_MIN  16'h0001
`define EPM_SF_MAX  16'h00C8
`define EPM_OILW_MIN 16'h000B
`define EPM_OILS_MIN 16'h0009
`define EPM_OIL_MAX  16'h0064
`define EPM_CT_MIN  16'h0096
`define EPM_CT_MAX  16'h0122
`define EPM_UT_MAX  16'h0064
`define EPM_CH12_HLO 16'h0082
`define EPM_CH12_HHI 16'h00C8
`define EPM_CH24_HLO 16'h00FA
`define EPM_CH24_HHI 16'h0190
`define EPM_CHL_MIN  16'h0014
`define EPM_D_2S    16'h0014
`define EPM_D_OC    16'h0258
`define EPM_D_SFMIN 16'h0002
`define EPM_D_SFMAX 16'h0064
`define EPM_D_OILW  16'h0096
`define EPM_D_10S   16'h0064
`define EPM_D_CHG   16'h0BB8
`define EPM_SD_MASK 10'b00_0101_0111
`endif

// ### core/epm_monitor.v
// Purpose: engine protection monitor with persistence timers and shutdown latch
// Assumes: sensor inputs come from logic on clk_sys_in; Wishbone classic slave
// Notes: channel order oc-shutdown, overspeed, conflict, oil warn, oil shutdown,
// Notes: coolant warn, coolant shutdown, coolant cold, charger, oc warn
`timescale 1ns/1ps
`include "epm_defs.vh"
module epm_monitor #(
  parameter        TICK_CYCLES = `EPM_TICK_MS * `EPM_CLK_KHZ,
  parameter [15:0] FC_OC_WARN  = 16'h0001
) (
  input  wire        clk_sys_in,
  input  wire        rst_in,
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [5:0]  wb_adr_in,
  input  wire [3:0]  wb_sel_in,
  input  wire [31:0] wb_dat_in,
  output wire [31:0] wb_dat_out,
  output wire        wb_ack_out,
  input  wire [15:0] cur_amps_in,
  input  wire [12:0] speed_rpm_in,
  input  wire [9:0]  freq_dhz_in,
  input  wire [7:0]  oil_psi_in,
  input  wire [8:0]  cool_degf_in,
  input  wire [8:0]  chg_dv_in,
  output wire        engine_stop_out,
  output wire        shutdown_out,
  output wire        warning_out,
  output wire [15:0] fault_code_out
);
  localparam TW = $clog2(TICK_CYCLES + 1);
  localparam NCH = 10;

  reg  [31:0]     cfg_q [0:`EPM_NCFG-1];
  reg  [31:0]     dat_q;
  reg             ack_q;
  reg  [TW-1:0]   tdiv_q;
  reg             tick_q;
  reg  [NCH-1:0]  sd_q;
  reg             stop_q;
  reg             shut_q;
  reg             warn_q;
  reg  [15:0]     code_q;
  reg  [15:0]     code_d;
  reg  [31:0]     rdata;
  reg  [15:0]     os_max;
  reg  [15:0]     ratio;
  wire [NCH-1:0]  cond;
  wire [NCH-1:0]  elapsed;
  wire [NCH*12-1:0] dly_all;
  wire [NCH-1:0]  sd_d;
  wire [NCH-1:0]  warn_now;
  integer         i;

  function [15:0] clamp;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  function [31:0] rstval;
    input [3:0] idx;
    begin
      case (idx)
        `EPM_R_CTRL: rstval = `EPM_RST_CTRL;
        `EPM_R_OC:   rstval = `EPM_RST_OC;
        `EPM_R_SPD:  rstval = `EPM_RST_SPD;
        `EPM_R_SF:   rstval = `EPM_RST_SF;
        `EPM_R_OIL:  rstval = `EPM_RST_OIL;
        `EPM_R_CT:   rstval = `EPM_RST_CT;
        `EPM_R_UT:   rstval = `EPM_RST_UT;
        `EPM_R_CHG:  rstval = `EPM_RST_CHG;
        `EPM_R_DLYA: rstval = `EPM_RST_DLYA;
        `EPM_R_DLYB: rstval = `EPM_RST_DLYB;
        `EPM_R_DLYC: rstval = `EPM_RST_DLYC;
        default:     rstval = `EPM_RST_DLYD;
      endcase
    end
  endfunction

  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer b;
    begin
      wmerge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b])
          wmerge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction

  // bus access decode
  wire       acc      = wb_cyc_in & wb_stb_in & ~ack_q;
  wire [3:0] idx      = wb_adr_in[5:2];
  wire       wr_cfg   = acc & wb_we_in & (idx < `EPM_R_STAT);
  wire       fault_rst = acc & wb_we_in & (idx == `EPM_R_CTRL) & wb_sel_in[0] & wb_dat_in[`EPM_B_FRST];

  wire [31:0] ctrl    = cfg_q[`EPM_R_CTRL];
  wire        f60     = ctrl[`EPM_B_F60];
  wire        b24     = ctrl[`EPM_B_B24];
  wire        gov     = ctrl[`EPM_B_GOV];
  wire [1:0]  rsel    = ctrl[5:4];

  // overspeed step limit and rpm/Hz ratio
  always @* begin
    case ({f60, rsel})
      3'b000:  os_max = `EPM_OS50_20;
      3'b001:  os_max = `EPM_OS50_30;
      3'b010:  os_max = `EPM_OS50_60;
      3'b100:  os_max = `EPM_OS60_20;
      3'b101:  os_max = `EPM_OS60_30;
      3'b110:  os_max = `EPM_OS60_60;
      3'b111:  os_max = `EPM_OS60_20;
      default: os_max = `EPM_OS50_20;
    endcase
    case (rsel)
      2'd1:    ratio = 16'd30;
      2'd2:    ratio = 16'd60;
      default: ratio = 16'd20;
    endcase
  end

  // effective thresholds, clamped to legal ranges
  wire [15:0] os_st   = clamp({8'd0, cfg_q[`EPM_R_SPD][7:0]}, 16'd0, os_max);
  wire [12:0] os_rpm  = {5'd0, os_st[7:0]} * 13'd25;
  wire [15:0] sf_thr  = clamp({8'd0, cfg_q[`EPM_R_SF][7:0]}, `EPM_SF_MIN, `EPM_SF_MAX);
  wire [15:0] oilw    = clamp({8'd0, cfg_q[`EPM_R_OIL][7:0]}, `EPM_OILW_MIN, `EPM_OIL_MAX);
  wire [15:0] oils    = clamp({8'd0, cfg_q[`EPM_R_OIL][15:8]}, `EPM_OILS_MIN, `EPM_OIL_MAX);
  wire [15:0] ctw     = clamp({7'd0, cfg_q[`EPM_R_CT][8:0]}, `EPM_CT_MIN, `EPM_CT_MAX);
  wire [15:0] cts     = clamp({7'd0, cfg_q[`EPM_R_CT][24:16]}, `EPM_CT_MIN, `EPM_CT_MAX);
  wire [15:0] utt     = clamp({9'd0, cfg_q[`EPM_R_UT][6:0]}, 16'd0, `EPM_UT_MAX);
  wire [15:0] chh     = b24 ? clamp({7'd0, cfg_q[`EPM_R_CHG][8:0]}, `EPM_CH24_HLO, `EPM_CH24_HHI)
                            : clamp({7'd0, cfg_q[`EPM_R_CHG][8:0]}, `EPM_CH12_HLO, `EPM_CH12_HHI);
  wire [15:0] chl     = clamp({7'd0, cfg_q[`EPM_R_CHG][24:16]}, `EPM_CHL_MIN,
                              b24 ? `EPM_CH24_HLO : `EPM_CH12_HLO);

  // persistence delays in ticks
  wire [15:0] d_oc    = clamp({6'd0, cfg_q[`EPM_R_DLYA][9:0]}, `EPM_D_2S, `EPM_D_OC);
  wire [15:0] d_sf    = clamp({9'd0, cfg_q[`EPM_R_DLYA][22:16]}, `EPM_D_SFMIN, `EPM_D_SFMAX);
  wire [15:0] d_oilw  = clamp({8'd0, cfg_q[`EPM_R_DLYB][7:0]}, `EPM_D_2S, `EPM_D_OILW);
  wire [15:0] d_oils  = clamp({8'd0, cfg_q[`EPM_R_DLYB][23:16]}, `EPM_D_2S, `EPM_D_10S);
  wire [15:0] d_ctw   = clamp({8'd0, cfg_q[`EPM_R_DLYC][7:0]}, `EPM_D_2S, `EPM_D_10S);
  wire [15:0] d_cts   = clamp({8'd0, cfg_q[`EPM_R_DLYC][23:16]}, `EPM_D_2S, `EPM_D_10S);
  wire [15:0] d_chg   = clamp({4'd0, cfg_q[`EPM_R_DLYD][11:0]}, `EPM_D_2S, `EPM_D_CHG);
  wire [31:0] d_ut    = `EPM_UT_TICKS;

  assign dly_all = {12'd0, d_chg[11:0], d_ut[11:0], d_cts[11:0], d_ctw[11:0],
                    d_oils[11:0], d_oilw[11:0], d_sf[11:0], 12'd0, d_oc[11:0]};

  // speed/frequency comparison in tenths of a hertz times ratio
  wire [17:0] eng10   = {5'd0, speed_rpm_in} * 18'd10;
  wire [17:0] gen10   = {8'd0, freq_dhz_in} * ratio[7:0];
  wire [17:0] sf_diff = (eng10 > gen10) ? (eng10 - gen10) : (gen10 - eng10);
  wire [17:0] sf_lim  = {10'd0, sf_thr[7:0]} * ratio[7:0];

  // fault conditions
  assign cond[0] = cur_amps_in > cfg_q[`EPM_R_OC][15:0];
  assign cond[1] = gov & (speed_rpm_in > os_rpm);
  assign cond[2] = sf_diff > sf_lim;
  assign cond[3] = {8'd0, oil_psi_in} <= oilw;
  assign cond[4] = {8'd0, oil_psi_in} <= oils;
  assign cond[5] = {7'd0, cool_degf_in} >= ctw;
  assign cond[6] = {7'd0, cool_degf_in} >= cts;
  assign cond[7] = {7'd0, cool_degf_in} < utt;
  assign cond[8] = ({7'd0, chg_dv_in} >= chh) | ({7'd0, chg_dv_in} <= chl);
  assign cond[9] = cur_amps_in > cfg_q[`EPM_R_OC][31:16];

  // timebase tick
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      tdiv_q <= {TW{1'b0}};
      tick_q <= 1'b0;
    end else if (tdiv_q == TICK_CYCLES - 1) begin
      tdiv_q <= {TW{1'b0}};
      tick_q <= 1'b1;
    end else begin
      tdiv_q <= tdiv_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // persistence timers, one per channel
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gen_tmr
      reg  [11:0] cnt_q;
      wire        done = cond[g] & (cnt_q >= dly_all[g*12 +: 12]);
      always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in)
          cnt_q <= 12'd0;
        else if (!cond[g])
          cnt_q <= 12'd0;
        else if (tick_q && !done)
          cnt_q <= cnt_q + 12'd1;
      end
      assign elapsed[g] = done;
    end
  endgenerate

  // shutdown latch, set wins over fault reset
  assign sd_d     = (sd_q & ~{NCH{fault_rst}}) | (elapsed & `EPM_SD_MASK);
  assign warn_now = elapsed & ~`EPM_SD_MASK;

  // displayed code, shutdowns before warnings
  always @* begin
    code_d = 16'h0000;
    if (sd_d[0])
      code_d = `EPM_FC_OCS;
    else if (sd_d[1])
      code_d = `EPM_FC_OS;
    else if (sd_d[2])
      code_d = `EPM_FC_SF;
    else if (sd_d[4])
      code_d = `EPM_FC_OILS;
    else if (sd_d[6])
      code_d = `EPM_FC_CTS;
    else if (warn_now[3])
      code_d = `EPM_FC_OILW;
    else if (warn_now[5])
      code_d = `EPM_FC_CTW;
    else if (warn_now[7])
      code_d = `EPM_FC_UT;
    else if (warn_now[8])
      code_d = `EPM_FC_CHG;
    else if (warn_now[9])
      code_d = FC_OC_WARN;
  end

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sd_q   <= {NCH{1'b0}};
      stop_q <= 1'b0;
      shut_q <= 1'b0;
      warn_q <= 1'b0;
      code_q <= 16'h0000;
    end else begin
      sd_q   <= sd_d;
      stop_q <= |sd_d;
      shut_q <= |sd_d;
      warn_q <= |warn_now;
      code_q <= code_d;
    end
  end

  // register read mux
  always @* begin
    case (idx)
      `EPM_R_STAT: rdata = {stop_q, 5'd0, sd_q, 6'd0, elapsed};
      `EPM_R_CODE: rdata = {16'd0, code_q};
      default:     rdata = (idx < `EPM_R_STAT) ? cfg_q[idx] : 32'h0000_0000;
    endcase
  end

  // wishbone slave, one wait-free answer per request
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
      for (i = 0; i < `EPM_NCFG; i = i + 1)
        cfg_q[i] <= rstval(i[3:0]);
    end else begin
      ack_q <= acc;
      if (acc && !wb_we_in)
        dat_q <= rdata;
      if (wr_cfg)
        cfg_q[idx] <= wmerge(cfg_q[idx], wb_dat_in, wb_sel_in) & ~((idx == `EPM_R_CTRL) ? 32'h0000_0001 : 32'h0);
    end
  end

  assign wb_dat_out      = dat_q;
  assign wb_ack_out      = ack_q;
  assign engine_stop_out = stop_q;
  assign shutdown_out    = shut_q;
  assign warning_out     = warn_q;
  assign fault_code_out  = code_q;
endmodule // epm_monitor

// ### tb/epm_monitor_asserts.sv
// Purpose: port level checker for the protection monitor
// Assumes: one clock domain, asynchronous active high reset
// Notes: warnings may trail their cause by up to three clocks
`timescale 1ns/1ps
module epm_monitor_asserts #(
  parameter        TICK_CYCLES = 10,
  parameter [15:0] FC_OC_WARN  = 16'h0001
) (
  input wire        clk_sys_in,
  input wire        rst_in,
  input wire        wb_cyc_in,
  input wire        wb_stb_in,
  input wire        wb_we_in,
  input wire [5:0]  wb_adr_in,
  input wire [3:0]  wb_sel_in,
  input wire [31:0] wb_dat_in,
  input wire        wb_ack_out,
  input wire [7:0]  oil_psi_in,
  input wire [8:0]  cool_degf_in,
  input wire        engine_stop_out,
  input wire        shutdown_out,
  input wire [15:0] fault_code_out
);
  wire clr_w = wb_cyc_in & wb_stb_in & wb_we_in & ~wb_ack_out
             & (wb_adr_in[5:2] == 4'h0) & wb_sel_in[0] & wb_dat_in[0];
  wire sd_w = (fault_code_out == 16'h05C0) | (fault_code_out == 16'h07C8)
            | (fault_code_out == 16'h05BD) | (fault_code_out == 16'h019F)
            | (fault_code_out == 16'h0097);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  ack_once_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("request not acknowledged");
  stop_mirror_a: assert property (engine_stop_out == shutdown_out)
    else $error("stop and shutdown differ");
  stop_hold_a: assert property ($fell(engine_stop_out) |->
    $past(clr_w) || $past(clr_w, 2) || $past(clr_w, 3))
    else $error("stop dropped without fault reset");
  stop_code_a: assert property (engine_stop_out == sd_w)
    else $error("stop and shown code disagree");
  oil_src_a: assert property (fault_code_out == 16'h008F |->
    $past(oil_psi_in) <= 8'h64 || $past(oil_psi_in, 2) <= 8'h64 || $past(oil_psi_in, 3) <= 8'h64)
    else $error("oil warning without low pressure");
  hot_src_a: assert property (fault_code_out == 16'h0092 |->
    $past(cool_degf_in) >= 9'h096 || $past(cool_degf_in, 2) >= 9'h096 || $past(cool_degf_in, 3) >= 9'h096)
    else $error("hot warning below range");
  cold_src_a: assert property (fault_code_out == 16'h059B |->
    $past(cool_degf_in) < 9'h064 || $past(cool_degf_in, 2) < 9'h064 || $past(cool_degf_in, 3) < 9'h064)
    else $error("cold warning above range");
endmodule // epm_monitor_asserts

bind epm_monitor epm_monitor_asserts #(.TICK_CYCLES(TICK_CYCLES), .FC_OC_WARN(FC_OC_WARN)) u_asserts (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
  .wb_ack_out(wb_ack_out), .oil_psi_in(oil_psi_in), .cool_degf_in(cool_degf_in),
  .engine_stop_out(engine_stop_out), .shutdown_out(shutdown_out), .fault_code_out(fault_code_out));

// ### tb/epm_sensor_model.sv
// Purpose: sensor side model for the protection monitor
// Assumes: caller changes values right after a rising clock edge
// Notes: values hold until the bench changes them
`timescale 1ns/1ps
module epm_sensor_model (
  output logic [15:0] amps_out,
  output logic [12:0] rpm_out,
  output logic [9:0]  dhz_out,
  output logic [7:0]  psi_out,
  output logic [8:0]  degf_out,
  output logic [8:0]  dv_out
);
  task automatic put(input int k, input int v);
    case (k)
      0: amps_out <= v[15:0];
      1: rpm_out <= v[12:0];
      2: dhz_out <= v[9:0];
      3: psi_out <= v[7:0];
      4: degf_out <= v[8:0];
      default: dv_out <= v[8:0];
    endcase
  endtask
  // healthy set at 50 Hz and 20 rpm/Hz
  task automatic normal();
    put(0, 100);
    put(1, 1000);
    put(2, 500);
    put(3, 50);
    put(4, 120);
    put(5, 140);
  endtask
  initial normal();
endmodule // epm_sensor_model

// ### tb/test_engine_protection_monitor.sv
// Purpose: self checking bench for the protection monitor
// Assumes: delay tick shortened to 10 clocks
// Notes: sensors come from the sensor model
`timescale 1ns/1ps
module test_engine_protection_monitor;
  localparam [15:0] OC_W = 16'h0123; // arbitrary warning code
  logic        clk_sys_in, rst_in, cyc, stb, we;
  logic [5:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dw, q;
  wire  [31:0] dr;
  wire         ack, stop, sd, warn;
  wire  [15:0] code, amps;
  wire  [12:0] rpm;
  wire  [9:0]  dhz;
  wire  [7:0]  psi;
  wire  [8:0]  degf, dv;
  int          n_mismatch, n_tests, i, f, r, ra, mx;
  logic [5:0]  a0 [6] = '{6'h00, 6'h04, 6'h10, 6'h1C, 6'h20, 6'h3C};
  logic [31:0] v0 [6] = '{32'h0000_0008, 32'hFFFF_FFFF, 32'h0000_090B, 32'h0014_0190, 32'h0064_0258, 32'h0};
  logic [5:0]  a1 [8] = '{6'h20, 6'h24, 6'h28, 6'h2C, 6'h14, 6'h18, 6'h04, 6'h0C};
  logic [31:0] v1 [8] = '{32'h0002_0014, 32'h0014_0014, 32'h0014_0014, 32'h0000_0014,
                          32'h0122_0096, 32'h0000_0064, 32'h0096_00C8, 32'h0000_0001};
  epm_sensor_model sensors (.amps_out(amps), .rpm_out(rpm), .dhz_out(dhz), .psi_out(psi),
    .degf_out(degf), .dv_out(dv));
  epm_monitor #(.TICK_CYCLES(10), .FC_OC_WARN(OC_W)) dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dw), .wb_dat_out(dr), .wb_ack_out(ack),
    .cur_amps_in(amps), .speed_rpm_in(rpm), .freq_dhz_in(dhz), .oil_psi_in(psi),
    .cool_degf_in(degf), .chg_dv_in(dv), .engine_stop_out(stop), .shutdown_out(sd),
    .warning_out(warn), .fault_code_out(code));
  always #5 clk_sys_in = ~clk_sys_in;
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g, input string nm);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic wb(input logic [5:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge clk_sys_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    sel <= 4'hF;
    k = 0;
    do begin
      @(posedge clk_sys_in);
      k++;
    end while (ack !== 1'b1 && k < 20);
    chk(1, ack, "bus ack");
    if (ack !== 1'b1) summarize();
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wait_ev(input logic s_only);
    int t;
    t = 0;
    while (!(stop === 1'b1 || (!s_only && warn === 1'b1)) && t < 400) begin
      @(posedge clk_sys_in);
      t++;
    end
    chk(1, t < 400, "fault event");
    if (t == 400) summarize();
    cyc_wait(2);
  endtask
  task automatic run_fault(input logic [31:0] c, input int k, input int v, input logic [15:0] e,
                           input logic s, input int pre);
    wb(6'h00, 1, c);
    sensors.put(k, v);
    cyc_wait(pre);
    chk(0, warn | stop, "early event");
    if (e != 0) wait_ev(0);
    chk(e, code, "fault code");
    chk(s, stop, "engine stop");
    sensors.normal();
    wb(6'h00, 1, c | 1);
    cyc_wait(3);
    chk(0, code, "cleared code");
  endtask
  initial begin
    clk_sys_in = 0;
    rst_in = 1;
    {cyc, stb, we, adr, sel, dw} = '0;
    n_mismatch = 0;
    n_tests = 0;
    cyc_wait(4);
    rst_in <= 1'b0;
    wb(6'h3C, 1, 32'hFFFF_FFFF);
    for (i = 0; i < 6; i++) begin
      wb(a0[i], 0, 0);
      chk(v0[i], q, "reset value");
    end
    for (i = 0; i < 8; i++) begin
      wb(a1[i], 1, v1[i]);
      wb(a1[i], 0, 0);
      chk(v1[i], q, "readback");
    end
    sensors.put(3, 11);
    cyc_wait(180);
    sensors.put(3, 50);
    cyc_wait(3);
    sensors.put(3, 11);
    cyc_wait(180);
    chk(0, warn, "restarted timer");
    sensors.put(3, 50);
    run_fault(32'h8, 3, 11, 16'h008F, 0, 180);
    run_fault(32'h8, 3, 9, 16'h019F, 1, 180);
    run_fault(32'h8, 4, 150, 16'h0092, 0, 180);
    run_fault(32'h8, 4, 290, 16'h0097, 1, 180);
    run_fault(32'h8, 4, 99, 16'h059B, 0, 5900);
    run_fault(32'h8, 5, 200, 16'h0A76, 0, 180);
    run_fault(32'h8, 5, 20, 16'h0A76, 0, 180);
    run_fault(32'hC, 5, 399, 16'h0, 0, 220);
    run_fault(32'hC, 5, 400, 16'h0A76, 0, 180);
    run_fault(32'h8, 2, 498, 16'h05BD, 1, 5);
    run_fault(32'h8, 2, 499, 16'h0, 0, 40);
    for (f = 0; f < 2; f++) begin
      for (r = 0; r < 3; r++) begin
        ra = (r == 0) ? 20 : (r == 1) ? 30 : 60;
        mx = (f ? 60 : 50) * ra * 5 / 4;
        sensors.put(1, 0);
        sensors.put(2, 0);
        wb(6'h00, 1, 8 | f << 1 | r << 4);
        sensors.put(1, mx);
        sensors.put(2, mx * 10 / ra);
        cyc_wait(5);
        chk(0, stop, "stop at limit");
        sensors.put(1, mx + 1);
        sensors.put(2, (mx + 1) * 10 / ra);
        cyc_wait(5);
        chk(1, stop, "overspeed stop");
        chk(16'h07C8, code, "overspeed code");
        sensors.put(1, 0);
        sensors.put(2, 0);
        wb(6'h00, 1, 9 | f << 1 | r << 4);
      end
    end
    wb(6'h08, 1, 32'h0000_0028);
    wb(6'h00, 1, 32'h0000_0038);
    sensors.normal();
    cyc_wait(40);
    chk(0, stop, "stop at set limit");
    sensors.put(1, 1001);
    cyc_wait(5);
    chk(1, stop, "stepped overspeed");
    sensors.put(1, 0);
    sensors.put(2, 0);
    wb(6'h00, 1, 32'h0000_0039);
    wb(6'h08, 1, 32'h0000_00FF);
    wb(6'h00, 1, 0);
    sensors.put(1, 2000);
    sensors.put(2, 1000);
    cyc_wait(5);
    chk(0, stop, "ungoverned overspeed");
    sensors.normal();
    wb(6'h00, 1, 8);
    sensors.put(0, 250);
    cyc_wait(5);
    chk(OC_W, code, "oc warning code");
    wait_ev(1);
    chk(16'h05C0, code, "oc shutdown code");
    sensors.put(0, 100);
    cyc_wait(50);
    chk(1, stop, "held stop");
    wb(6'h30, 0, 0);
    chk(32'h8001_0000, q, "status word");
    wb(6'h34, 0, 0);
    chk(32'h0000_05C0, q, "code word");
    wb(6'h00, 1, 9);
    cyc_wait(3);
    chk(0, stop, "stop after reset");
    summarize();
  end
endmodule // test_engine_protection_monitor
